// ==== pkg/remap_pin_defines.svh ====
// Register offsets, field positions and reset values of the pin output selectors
`ifndef REMAP_PIN_DEFINES_SVH
`define REMAP_PIN_DEFINES_SVH
`define OFS_PIN_OUT_SEL_20_21 4'h0
`define OFS_PIN_OUT_SEL_22_23 4'h1
`define OFS_PIN_OUT_SEL_24_25 4'h2
`define OFS_PIN_OUT_SEL_26_27 4'h3
`define OFS_PIN_OUT_SEL_28_29 4'h4
`define OFS_PIN_OUT_SEL_30_31 4'h5
`define SEL_ODD_MSB  13
`define SEL_ODD_LSB  8
`define SEL_EVEN_MSB 5
`define SEL_EVEN_LSB 0
`define SEL_RESET    6'h00
`define FUNC_NONE    6'h00
`define REG_RESET    16'h0000
`define PIN_RESET    12'h000
`define RSVD_HI_MSB  15
`define RSVD_HI_LSB  14
`define RSVD_LO_MSB  7
`define RSVD_LO_LSB  6
`endif

// ==== pkg/remap_pin_pkg.sv ====
// Types shared by the pin output selector
package remap_pin_pkg;
  typedef logic [5:0]  func_sel_t;   // One pin's function number
  typedef logic [15:0] reg_word_t;   // Register data word
  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    reg_word_t  wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
  // Bus states of the read path
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } rd_state_t;
endpackage : remap_pin_pkg

// ==== rtl/remap_pin_output_select.sv ====
// Output side of the remappable pin multiplexer for pins 20 to 31
//
// Decided for this implementation: the register addresses and the strobed register port.
`include "remap_pin_defines.svh"
module remap_pin_output_select
  import remap_pin_pkg::*;
#(
  parameter int NUM_FUNCS   = 64,  // Peripheral outputs numbered 0..NUM_FUNCS-1
  parameter bit SMALL_PKG   = 1'b0 // Smaller package without pins 30, 31
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 nrst,
  // Register port
  input  wire logic [3:0]           addr,
  input  wire logic [15:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output      logic [15:0]          rdata,
  // Peripheral outputs, indexed by function number
  input  wire logic [NUM_FUNCS-1:0] periphOut,
  // Remappable pins 20..31, bit 0 is pin 20
  output      logic [11:0]          remapPinOut,
  output      logic [11:0]          remapPinOe
);

  localparam int NPINS = 12;  // Pins in this block
  localparam int NREGS = 6;   // Selector registers

  // Register index of each selector pair; entry r serves pins 2r and 2r+1
  localparam logic [3:0] REG_OFS [NREGS] = '{
    `OFS_PIN_OUT_SEL_20_21,
    `OFS_PIN_OUT_SEL_22_23,
    `OFS_PIN_OUT_SEL_24_25,
    `OFS_PIN_OUT_SEL_26_27,
    `OFS_PIN_OUT_SEL_28_29,
    `OFS_PIN_OUT_SEL_30_31
  };

  // Six bits of selector can never address more than 64 outputs;
  // fewer than two would leave nothing but the idle code
  if (NUM_FUNCS < 2 || NUM_FUNCS > 64) begin : g_bad_num_funcs
    $error("NUM_FUNCS must be 2..64");
  end

  reg_req_t  req;                   // Bundled request
  func_sel_t sel_q [NPINS];         // Stored selectors, one per pin
  func_sel_t sel_d [NPINS];
  reg_word_t rdata_d;               // Next read data
  logic [NPINS-1:0] pinOut_d;       // Next pin levels
  logic [NPINS-1:0] pinOe_d;        // Next pin enables
  logic [63:0]      funcLevels;     // Peripheral levels padded to 64 entries

  // Strobes, index and data travel together from here on
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Padding to the full six-bit range means every selector value indexes a real
  // bit, so an out-of-range code never reads past the end of the input vector
  assign funcLevels = 64'(periphOut);

  // Pin present in this package; the smaller package never writes the
  // selectors of pins 30 and 31 and gates their enables, so nothing can ever enable them
  function automatic logic pinExists(input int p);
    return !(SMALL_PKG && p >= 10);
  endfunction : pinExists

  // Selector write decode; only the implemented bits are stored
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      sel_d[p] = sel_q[p];
      // Absent pins keep their reset value, so they also read back as zero
      if (req.wr && req.addr == REG_OFS[p / 2] && pinExists(p)) begin
        if (p % 2 == 1) sel_d[p] = req.wdata[`SEL_ODD_MSB:`SEL_ODD_LSB];
        else            sel_d[p] = req.wdata[`SEL_EVEN_MSB:`SEL_EVEN_LSB];
      end
    end
  end

  // Read mux; unimplemented bits and unmapped addresses give zero
  always_comb begin
    // Bus idles at zero between reads
    rdata_d = `REG_RESET;
    if (req.rd) begin
      // Only a matching index fills the word; any other index leaves zero
      for (int r = 0; r < NREGS; r++) begin
        if (req.addr == REG_OFS[r]) begin
          rdata_d[`SEL_ODD_MSB:`SEL_ODD_LSB]   = sel_q[2*r+1];
          rdata_d[`SEL_EVEN_MSB:`SEL_EVEN_LSB] = sel_q[2*r];
        end
      end
    end
    // Unimplemented positions are forced low whatever was stored
    rdata_d[`RSVD_HI_MSB:`RSVD_HI_LSB] = 2'h0;
    rdata_d[`RSVD_LO_MSB:`RSVD_LO_LSB] = 2'h0;
  end

  // Output routing from the stored selectors
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      // Zero and out-of-range numbers leave the pin undriven
      pinOe_d[p]  = (sel_q[p] != `FUNC_NONE) && (int'(sel_q[p]) < NUM_FUNCS)
                    && pinExists(p);
      // Undriven pins are held low so a released pin shows no stale level
      pinOut_d[p] = pinOe_d[p] ? funcLevels[sel_q[p]] : 1'b0;
    end
  end

  // Registers only; every output leaves a flip-flop so the pins see no
  // combinational glitch when a selector and a peripheral level change together
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      // Power-on state: no pin taken over by any peripheral
      for (int p = 0; p < NPINS; p++) sel_q[p] <= `SEL_RESET;
      rdata       <= `REG_RESET;
      remapPinOut <= `PIN_RESET;
      remapPinOe  <= `PIN_RESET;
    end else begin
      // Normal running
      for (int p = 0; p < NPINS; p++) sel_q[p] <= sel_d[p];
      rdata       <= rdata_d;
      remapPinOut <= pinOut_d;
      remapPinOe  <= pinOe_d;
    end
  end

  // Write lands in the selector and reads back in the cycle after a read
  property p_write_even;
    @(posedge clock) disable iff (!nrst)
      (wr && addr == 4'h0) |=> (sel_q[0] == $past(wdata[5:0]));
  endproperty
  a_write_even: assert property (p_write_even) else $error("even selector not written");

  property p_write_odd;
    @(posedge clock) disable iff (!nrst)
      (wr && addr == 4'h2) |=> (sel_q[5] == $past(wdata[13:8]));
  endproperty
  a_write_odd: assert property (p_write_odd) else $error("odd selector not written");

  property p_reserved_zero;
    @(posedge clock) disable iff (!nrst)
      (rdata[15:14] == 2'h0) && (rdata[7:6] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_readback;
    @(posedge clock) disable iff (!nrst)
      (rd && addr == 4'h1) |=> (rdata == {2'h0, sel_q[3], 2'h0, sel_q[2]});
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_zero_idle;
    @(posedge clock) disable iff (!nrst)
      (sel_q[0] == 6'h00) |=> !remapPinOe[0];
  endproperty
  a_zero_idle: assert property (p_zero_idle) else $error("zero selector drives pin");

  property p_route;
    @(posedge clock) disable iff (!nrst)
      (sel_q[1] != 6'h00 && int'(sel_q[1]) < NUM_FUNCS)
        |=> remapPinOe[1] && remapPinOut[1] == $past(periphOut[sel_q[1]]);
  endproperty
  a_route: assert property (p_route) else $error("pin not routed");

  property p_small_pkg;
    @(posedge clock) disable iff (!nrst)
      SMALL_PKG |-> (remapPinOe[11:10] == 2'b00 && sel_q[10] == 6'h00 && sel_q[11] == 6'h00);
  endproperty
  a_small_pkg: assert property (p_small_pkg) else $error("absent pins active");

  property p_unmapped_zero;
    @(posedge clock) disable iff (!nrst)
      (rd && addr > 4'h5) |=> (rdata == 16'h0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  // A write to any other index leaves the pin 20 and 21 selectors alone
  property p_keep_others;
    @(posedge clock) disable iff (!nrst)
      (wr && addr != 4'h0) |=> (sel_q[0] == $past(sel_q[0]) && sel_q[1] == $past(sel_q[1]));
  endproperty
  a_keep_others: assert property (p_keep_others) else $error("other index changed a selector");

  // Both fields of a middle register land together
  property p_write_mid;
    @(posedge clock) disable iff (!nrst)
      (wr && addr == 4'h3) |=> (sel_q[6] == $past(wdata[5:0]) && sel_q[7] == $past(wdata[13:8]));
  endproperty
  a_write_mid: assert property (p_write_mid) else $error("pin pair selectors not written");

  // Top pair only stores in the larger package
  property p_write_top;
    @(posedge clock) disable iff (!nrst)
      (wr && addr == 4'h5) |=> (sel_q[10] == (SMALL_PKG ? `SEL_RESET : $past(wdata[5:0])));
  endproperty
  a_write_top: assert property (p_write_top) else $error("top selector write wrong");

  // Top pair reads back its fields, or zero when absent
  property p_readback_top;
    @(posedge clock) disable iff (!nrst)
      (rd && addr == 4'h5)
        |=> (rdata == (SMALL_PKG ? `REG_RESET : {2'h0, sel_q[11], 2'h0, sel_q[10]}));
  endproperty
  a_readback_top: assert property (p_readback_top) else $error("top readback wrong");

  // A released pin is never left at a high level
  property p_undriven_low;
    @(posedge clock) disable iff (!nrst)
      ((remapPinOut & ~remapPinOe) == `PIN_RESET);
  endproperty
  a_undriven_low: assert property (p_undriven_low) else $error("undriven pin not low");

  // Pin 30 follows its peripheral one cycle later when present
  property p_route_top;
    @(posedge clock) disable iff (!nrst)
      (!SMALL_PKG && sel_q[10] != 6'h00 && int'(sel_q[10]) < NUM_FUNCS)
        |=> remapPinOe[10] && remapPinOut[10] == $past(periphOut[sel_q[10]]);
  endproperty
  a_route_top: assert property (p_route_top) else $error("pin 30 not routed");

endmodule : remap_pin_output_select

// ==== dv/tb_top.sv ====
// Self-checking bench for the remappable pin output selector
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;  // System clock
  logic        nrst;          // Async reset, active low
  logic [3:0]  addr;          // Register index
  logic [15:0] wdata;         // Write data
  logic        wr;            // Write strobe
  logic        rd;            // Read strobe
  logic [15:0] rdata;         // Read data, one cycle after rd
  logic [63:0] periphOut;     // Peripheral output levels
  logic [11:0] remapPinOut;   // Pin levels
  logic [11:0] remapPinOe;    // Pin drive enables
  logic [15:0] rdataSmall;    // Read data of the small-package instance
  logic [11:0] pinOutSmall;   // Its pin levels
  logic [11:0] pinOeSmall;    // Its pin drive enables
  logic [15:0] expWord;       // Expected register word
  logic [11:0] expOut;        // Expected pin levels
  int          errTotal = 0;
  int          comparisons = 0;

  remap_pin_output_select dut (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .periphOut, .remapPinOut, .remapPinOe);

  // Smaller package variant on the same bus and peripheral levels
  remap_pin_output_select #(
    .NUM_FUNCS (64),
    .SMALL_PKG (1'b1)
  ) dutSmall (
    .clock       (clock),
    .nrst        (nrst),
    .addr        (addr),
    .wdata       (wdata),
    .wr          (wr),
    .rd          (rd),
    .rdata       (rdataSmall),
    .periphOut   (periphOut),
    .remapPinOut (pinOutSmall),
    .remapPinOe  (pinOeSmall)
  );

  // Free-running 100 ns clock
  initial begin
    forever #50 clock = ~clock;
  end

  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle write; leading edge wait keeps strobes from colliding
  task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wrReg

  // One-cycle read, data checked in the following cycle only
  task automatic rdReg(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] expSmall);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
    chk("rdataSmall", expSmall, rdataSmall);
  endtask : rdReg

  // Pins lag the selectors by one register stage
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  // Report and end the run
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    nrst = 1'b0; addr = 4'h0; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
    periphOut = 64'hA5C3_96F0_1E2D_4B78;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    // Reset state: all clear, no pin driven
    for (int r = 0; r < 6; r++) rdReg(4'(r), 16'h0000, 16'h0000);
    chk("oe", 16'h0000, {4'h0, remapPinOe});
    // Pin i gets function i+1; reserved bits written high
    for (int r = 0; r < 6; r++) wrReg(4'(r), {2'b11, 6'(2*r+2), 2'b11, 6'(2*r+1)});
    // Small package keeps the top pair at zero
    for (int r = 0; r < 6; r++) begin
      expWord = {2'b00, 6'(2*r+2), 2'b00, 6'(2*r+1)};
      rdReg(4'(r), expWord, (r == 5) ? 16'h0000 : expWord);
    end
    settle();
    // Pins follow their peripheral, then its inverse
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 12; i++) expOut[i] = periphOut[i+1];
      chk("pins", {4'h0, expOut}, {4'h0, remapPinOut});
      chk("oe", 16'h0FFF, {4'h0, remapPinOe});
      chk("pinsSmall", {6'h00, expOut[9:0]}, {4'h0, pinOutSmall});
      chk("oeSmall", 16'h03FF, {4'h0, pinOeSmall});
      @(posedge clock);
      periphOut <= ~periphOut;
      settle();
    end
    // Zero on the even pin releases it; odd pin keeps driving
    wrReg(4'h0, 16'h0200);
    settle();
    chk("oe", 16'h0FFE, {4'h0, remapPinOe});
    chk("pin21", {15'h0, periphOut[2]}, {15'h0, remapPinOut[1]});
    chk("pin20", 16'h0000, {15'h0, remapPinOut[0]});
    // Unmapped index ignores writes and reads zero
    wrReg(4'hF, 16'hFFFF);
    rdReg(4'hF, 16'h0000, 16'h0000);
    rdReg(4'h0, 16'h0200, 16'h0200);
    // Reset in mid-run clears every selector and releases every pin
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    #1;
    chk("oeRst", 16'h0000, {4'h0, remapPinOe});
    chk("pinsRst", 16'h0000, {4'h0, remapPinOut});
    chk("oeSmallRst", 16'h0000, {4'h0, pinOeSmall});
    @(posedge clock);
    nrst <= 1'b1;
    rdReg(4'h0, 16'h0000, 16'h0000);
    rdReg(4'h5, 16'h0000, 16'h0000);
    print_verdict();
  end
endmodule : tb_top
